// File: pkg/gcp_cfg.svh
`ifndef GCP_CFG_SVH
`define GCP_CFG_SVH

// Bus commands (low seven data bits, ATN true)
`define GCP_SDC 8'h04
`define GCP_GET 8'h08
`define GCP_DCL 8'h14
`define GCP_SPE 8'h18
`define GCP_SPD 8'h19
`define GCP_UNL 8'h3f
`define GCP_LAD 3'h1
`define GCP_TAD 3'h2
`define GCP_RQS 6

// Device-dependent characters
`define GCP_CH_A 8'h41
`define GCP_CH_X 8'h58
`define GCP_CH_F 8'h46
`define GCP_CH_K 8'h4b
`define GCP_CH_R 8'h52
`define GCP_CH_S 8'h53
`define GCP_CH_T 8'h54
`define GCP_CH_V 8'h56
`define GCP_CH_W 8'h57
`define GCP_CH_Z 8'h5a
`define GCP_CH_SP 8'h20
`define GCP_CH_COMMA 8'h2c
`define GCP_CH_MINUS 8'h2d
`define GCP_CH_0 8'h30
`define GCP_CH_9 8'h39

// Parameter limits
`define GCP_MAX_F 16'h0002
`define GCP_MAX_R 16'h0009
`define GCP_MAX_S 16'h0004
`define GCP_MAX_K 16'h0003
`define GCP_MAX_Z 16'h0001
`define GCP_MAX_TMODE 16'h0004
`define GCP_MAX_TSHAPE 16'h0001
`define GCP_MAX_BIAS 16'h0014
`define GCP_MAX_WAVE 16'h0005
`define GCP_MIN_TIME 16'h0001
`define GCP_MAX_TIME 16'hfde8
`define GCP_ACC_SAT 20'h0ffff
`define GCP_TEN 20'h0000a
`define GCP_TM_GET 3'h1
`define GCP_TM_X 3'h2

// Buffer
`define GCP_BUF_DEPTH 32
`define GCP_CNT_W 6
`define GCP_CNT_FULL 6'h20

`endif

// File: pkg/gcp_pkg.sv
`include "gcp_cfg.svh"
`default_nettype none
package gcp_pkg;

    typedef enum logic {GCP_COLLECT, GCP_SCAN} gcp_st_t;

    typedef struct packed {
        logic [1:0]       freq;
        logic [3:0]       range;
        logic [2:0]       rate;
        logic [2:0]       tmode;
        logic             tshape;
        logic [3:0][5:0]  bias;
        logic [2:0]       wave;
        logic [2:0][15:0] wtime;
        logic [1:0]       kopt;
        logic             zopt;
    } gcp_cfg_t;

    typedef struct packed {
        gcp_st_t                           st;
        logic [`GCP_BUF_DEPTH-1:0][7:0]    buff;
        logic [`GCP_CNT_W-1:0]             cnt;
        logic [`GCP_CNT_W-1:0]             idx;
        gcp_cfg_t                          live;
        gcp_cfg_t                          sh;
        logic [7:0]                        cmd;
        logic [1:0]                        pidx;
        logic [15:0]                       acc;
        logic                              neg;
        logic                              have;
        logic                              any;
        logic                              cerr;
        logic                              oerr;
        logic                              ovf;
        logic                              lstn;
        logic                              talk;
        logic                              spe;
        logic                              bad_cmd;
        logic                              bad_opt;
        logic                              srq;
        logic                              restore;
        logic                              drift_clr;
        logic                              trig_single;
        logic                              trig_sweep;
        logic                              dio_oe;
        logic                              nrfd;
        logic [7:0]                        dio_out;
    } gcp_state_t;

endpackage
`default_nettype wire

// File: tb/gcp_bus_ctrl.sv
`default_nettype none
module gcp_bus_ctrl (
    // Clock
    input  wire logic       core_clk,
    // Controller drive
    output logic            atn,
    output logic            dav,
    output logic [7:0]      dio
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        atn = 1'b0;
        dav = 1'b0;
        dio = 8'h00;
    end

    // Command bytes always travel under ATN
    task automatic cmd(input logic [7:0] b);
        @(posedge core_clk);
        atn <= 1'b1;
        dav <= 1'b1;
        dio <= b;
    endtask

    task automatic dat(input logic [7:0] b);
        @(posedge core_clk);
        atn <= 1'b0;
        dav <= 1'b1;
        dio <= b;
    endtask

    // Released lines show the inverse, so a stale byte cannot pass as valid
    task automatic idle(input logic a);
        @(posedge core_clk);
        atn <= a;
        dav <= 1'b0;
        dio <= ~dio;
    endtask
endmodule
`default_nettype wire

// File: tb/gcp_parser_tb.sv
`include "gcp_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module gcp_parser_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  core_clk = 1'b0;
    logic                  nrst = 1'b0;
    logic [4:0]            my_addr;
    logic [4:0]            oth;
    logic [7:0]            status_byte;
    logic                  srq_on_error;
    logic                  atn;
    logic                  dav;
    logic [7:0]            ctl_dio;
    logic [7:0]            dio_in;
    logic [7:0]            dio_out;
    logic                  dio_oe;
    logic                  nrfd;
    logic                  srq;
    logic                  bad_command_error;
    logic                  bad_option_error;
    logic                  restore_setup1;
    logic                  drift_null_clear;
    logic                  trig_single;
    logic                  trig_sweep;
    logic [1:0]            freq_q;
    logic [3:0]            range_q;
    logic [2:0]            rate_q;
    logic [2:0]            trig_mode_q;
    logic                  trig_shape_q;
    logic [3:0][5:0]       bias_level_q;
    logic [2:0]            wave_q;
    logic [2:0][15:0]      wave_time_q;
    logic [1:0]            k_opt_q;
    logic                  z_opt_q;
    logic [106:0]          obs;
    logic [106:0]          got;
    logic [106:0]          q[$];
    gcp_pkg::gcp_cfg_t     exp_cfg;
    logic                  exp_bc;
    logic                  exp_bo;
    logic                  exp_srq;
    logic                  nrfd_p = 1'b0;
    logic                  oe_p = 1'b0;
    int                    err_count = 0;
    int                    total_checks = 0;
    int                    d;
    string                 ov = "";
    string                 bad_s [4] = '{"K7X", "V30X", "W123X", "R2E1X"};
    logic                  bad_c [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

    always #2 core_clk = ~core_clk;

    // Device output lags ATN by a cycle, so ATN hands the lines back at once
    assign dio_in = (dio_oe && !atn) ? dio_out : ctl_dio;
    assign obs = {restore_setup1, drift_null_clear, trig_single, trig_sweep, bad_command_error,
                  bad_option_error, srq, dio_oe, dio_oe ? dio_out : 8'h00, freq_q, range_q,
                  rate_q, trig_mode_q, trig_shape_q, bias_level_q, wave_q, wave_time_q,
                  k_opt_q, z_opt_q};

    gcp_bus_ctrl i_ctl (.core_clk(core_clk), .atn(atn), .dav(dav), .dio(ctl_dio));

    gcp_parser i_dut (
        .core_clk(core_clk), .nrst(nrst), .atn(atn), .dav(dav), .dio_in(dio_in),
        .dio_out(dio_out), .dio_oe(dio_oe), .nrfd(nrfd), .my_addr(my_addr),
        .status_byte(status_byte), .srq_on_error(srq_on_error), .srq(srq),
        .bad_command_error(bad_command_error), .bad_option_error(bad_option_error),
        .restore_setup1(restore_setup1), .drift_null_clear(drift_null_clear),
        .trig_single(trig_single), .trig_sweep(trig_sweep), .freq_q(freq_q),
        .range_q(range_q), .rate_q(rate_q), .trig_mode_q(trig_mode_q),
        .trig_shape_q(trig_shape_q), .bias_level_q(bias_level_q), .wave_q(wave_q),
        .wave_time_q(wave_time_q), .k_opt_q(k_opt_q), .z_opt_q(z_opt_q));

    function automatic logic [106:0] note(input logic [3:0] p, input logic oe,
                                          input logic [7:0] dv);
        return {p, exp_bc, exp_bo, exp_srq, oe, dv, exp_cfg};
    endfunction

    // Any pulse, end of a string check or start of a poll answer is a result
    always @(negedge core_clk) begin
        if (nrst && (|obs[106:103] || (nrfd_p && !nrfd) || (!oe_p && dio_oe))) begin
            if (q.size() == 0) begin
                `CHK("unexpected event", 1'b0, 1'b1)
            end else begin
                got = q.pop_front();
                `CHK("outputs", got, obs)
            end
        end
        nrfd_p <= nrfd;
        oe_p <= dio_oe;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic str(input string s, input logic fin);
        int k;
        for (int i = 0; i < s.len(); i++)
            i_ctl.dat(s[i]);
        i_ctl.idle(1'b0);
        repeat (2) @(posedge core_clk);
        if (fin) begin
            for (k = 0; k < 100 && nrfd !== 1'b0; k++)
                @(posedge core_clk);
            repeat (2) @(posedge core_clk);
        end
    endtask

    task automatic run(input string s);
        q.push_back(note(4'h0, 1'b0, 8'h00));
        str(s, 1'b1);
    endtask

    task automatic bus(input logic [7:0] b, input logic lvl);
        i_ctl.cmd(b);
        i_ctl.idle(lvl);
        repeat (4) @(posedge core_clk);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        test_done();
    end

    initial begin
        void'($urandom(91463));
        my_addr = 5'($urandom % 31);
        oth = (my_addr == 5'h00) ? 5'h01 : 5'h00;
        status_byte = 8'($urandom);
        srq_on_error = 1'b0;
        exp_cfg = '0;
        exp_bc = 1'b0;
        exp_bo = 1'b0;
        exp_srq = 1'b0;
        repeat (33) ov = {ov, " "};
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        bus({`GCP_LAD, my_addr}, 1'b1);
        d = $urandom % 10;
        str($sformatf("R%0d", d), 1'b0);
        @(negedge core_clk);
        `CHK("range before run marker", 4'h0, range_q)
        exp_cfg.range = 4'(d);
        run("X");
        exp_cfg.range = 4'h4;
        run("R4X");
        exp_cfg = '{freq: 2'h1, range: 4'h1, rate: 3'h2, kopt: 2'h3, zopt: 1'b1, default: '0};
        run("R1F1S2K3Z 1X");
        exp_cfg.bias = {6'h00, 6'h01, 6'h05, 6'h0a};
        run("V10,5,1,0X");
        exp_cfg.bias[3] = 6'h05;
        run("V,,,5X");
        exp_cfg.bias[0] = 6'h3d;
        run("V-3X");
        exp_cfg.wave = 3'h1;
        exp_cfg.wtime = {16'h000a, 16'h0032, 16'h0064};
        run("W1,100,50,10X");
        exp_cfg.wave = 3'h2;
        run("W2X");
        srq_on_error <= 1'b1;
        str("E1", 1'b0);
        @(negedge core_clk);
        `CHK("error before run marker", 1'b0, bad_command_error)
        exp_bc = 1'b1;
        exp_srq = 1'b1;
        run("X");
        for (int i = 0; i < 4; i++) begin
            exp_bc = bad_c[i];
            exp_bo = !bad_c[i];
            run(bad_s[i]);
        end
        // One byte more than the buffer holds voids the string
        exp_bc = 1'b1;
        exp_bo = 1'b0;
        run({ov, "X"});
        srq_on_error <= 1'b0;
        exp_bc = 1'b0;
        exp_bo = 1'b0;
        exp_cfg.range = 4'h5;
        run("R5X");
        i_ctl.cmd(`GCP_SPE);
        exp_srq = 1'b0;
        q.push_back(note(4'h0, 1'b1, {status_byte[7], 1'b1, status_byte[5:0]}));
        bus({`GCP_TAD, my_addr}, 1'b0);
        bus({`GCP_TAD, oth}, 1'b0);
        q.push_back(note(4'h0, 1'b1, {status_byte[7], 1'b0, status_byte[5:0]}));
        bus({`GCP_TAD, my_addr}, 1'b0);
        i_ctl.cmd(`GCP_SPD);
        bus({`GCP_TAD, my_addr}, 1'b0);
        // Mode two fires on its own execute, GET must then do nothing
        for (int m = 0; m < 5; m++) begin
            exp_cfg.tmode = 3'(m);
            exp_cfg.tshape = m[0];
            q.push_back(note((m == 2) ? 4'h2 : 4'h0, 1'b0, 8'h00));
            str($sformatf("T%0d,%0dX", m, m % 2), 1'b1);
            if (m == 1)
                q.push_back(note(4'h1, 1'b0, 8'h00));
            bus(`GCP_GET, 1'b1);
        end
        exp_cfg.tmode = 3'h1;
        exp_cfg.tshape = 1'b0;
        run("T1,0X");
        q.push_back(note(4'h2, 1'b0, 8'h00));
        bus(`GCP_GET, 1'b1);
        i_ctl.cmd(`GCP_UNL);
        i_ctl.cmd(`GCP_GET);
        bus(`GCP_SDC, 1'b1);
        q.push_back(note(4'h4, 1'b0, 8'h00));
        bus(`GCP_DCL, 1'b1);
        i_ctl.cmd({`GCP_LAD, my_addr});
        exp_cfg = '0;
        q.push_back(note(4'hc, 1'b0, 8'h00));
        bus(`GCP_SDC, 1'b1);
        repeat (8) @(posedge core_clk);
        `CHK("results missing", 0, q.size())
        test_done();
    end
endmodule
`undef CHK
`default_nettype wire

// File: verilog/gcp_parser.sv
// Overview of operation
// - SDC while listening restores defaults and asks for setup one recall.
// - SDC is ignored unless this device is the addressed listener.
// - GET fires one-shot or sweep only when trigger mode is GET.
// - SPE under ATN enters serial-poll-enabled state.
// - Poll enabled, talk addressed, ATN false: status byte driven out.
// - Each new talk address gets a status byte without a fresh SPE.
// - A command is one capital letter followed by numeric characters.
// - Multi-parameter commands split at commas, assigned by position.
// - Characters are buffered and only executed when X arrives.
// - Any invalid command voids the whole string and flags an error.
// - Validation happens only after X; no earlier error.
// - Spaces are discarded.
// - Unknown letters and undefined options are rejected.
// - Bias magnitude above twenty makes the string invalid.
// - Run-together multi-parameter digits are invalid, not reinterpreted.
// - Parameters skipped by bare commas keep their old values.
// - Omitted trailing parameters keep their old values.
// - Bias parameters are first, last, step, default level.
// - Range option four selects the two nanofarad range.
// - Waveform first parameter picks shape; then start, stop, step times.
// - DCL or SDC cancels drift-null constants.
// - Buffered commands apply in fixed category order, X splits groups.
`include "gcp_cfg.svh"
`default_nettype none
module gcp_parser (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    // Bus side
    input  wire logic                 atn,
    input  wire logic                 dav,
    input  wire logic [7:0]           dio_in,
    output logic      [7:0]           dio_out,
    output logic                      dio_oe,
    output logic                      nrfd,
    // Device side
    input  wire logic [4:0]           my_addr,
    input  wire logic [7:0]           status_byte,
    input  wire logic                 srq_on_error,
    output logic                      srq,
    output logic                      bad_command_error,
    output logic                      bad_option_error,
    output logic                      restore_setup1,
    output logic                      drift_null_clear,
    output logic                      trig_single,
    output logic                      trig_sweep,
    // Live configuration
    output logic      [1:0]           freq_q,
    output logic      [3:0]           range_q,
    output logic      [2:0]           rate_q,
    output logic      [2:0]           trig_mode_q,
    output logic                      trig_shape_q,
    output logic      [3:0][5:0]      bias_level_q,
    output logic      [2:0]           wave_q,
    output logic      [2:0][15:0]     wave_time_q,
    output logic      [1:0]           k_opt_q,
    output logic                      z_opt_q
);

    gcp_pkg::gcp_state_t s_q;
    gcp_pkg::gcp_state_t s_d;

    function automatic logic [2:0] nparam(logic [7:0] c);
        case (c)
            `GCP_CH_F, `GCP_CH_R, `GCP_CH_S, `GCP_CH_K, `GCP_CH_Z: nparam = 3'h1;
            `GCP_CH_T: nparam = 3'h2;
            `GCP_CH_V, `GCP_CH_W: nparam = 3'h4;
            default: nparam = 3'h0;
        endcase
    endfunction

    function automatic logic param_ok(logic [7:0] c, logic [1:0] p, logic [15:0] v,
                                      logic ng);
        param_ok = 1'b0;
        case (c)
            `GCP_CH_F: param_ok = v <= `GCP_MAX_F;
            `GCP_CH_R: param_ok = v <= `GCP_MAX_R;
            `GCP_CH_S: param_ok = v <= `GCP_MAX_S;
            `GCP_CH_K: param_ok = v <= `GCP_MAX_K;
            `GCP_CH_Z: param_ok = v <= `GCP_MAX_Z;
            `GCP_CH_T: param_ok = v <= (p == 2'h0 ? `GCP_MAX_TMODE : `GCP_MAX_TSHAPE);
            `GCP_CH_V: param_ok = v <= `GCP_MAX_BIAS;
            `GCP_CH_W: param_ok = (p == 2'h0) ? v <= `GCP_MAX_WAVE
                                  : (v >= `GCP_MIN_TIME && v <= `GCP_MAX_TIME);
            default: param_ok = 1'b0;
        endcase
        if (ng && c != `GCP_CH_V) begin
            param_ok = 1'b0;
        end
    endfunction

    // Writes one checked value into its positional slot
    function automatic gcp_pkg::gcp_cfg_t store(gcp_pkg::gcp_cfg_t cf, logic [7:0] c,
                                                 logic [1:0] p, logic [15:0] v, logic ng);
        store = cf;
        case (c)
            `GCP_CH_F: store.freq = v[1:0];
            `GCP_CH_R: store.range = v[3:0];
            `GCP_CH_S: store.rate = v[2:0];
            `GCP_CH_K: store.kopt = v[1:0];
            `GCP_CH_Z: store.zopt = v[0];
            `GCP_CH_T: begin
                if (p == 2'h0) begin
                    store.tmode = v[2:0];
                end else begin
                    store.tshape = v[0];
                end
            end
            `GCP_CH_V: store.bias[p] = ng ? 6'(-v[5:0]) : v[5:0];
            `GCP_CH_W: begin
                if (p == 2'h0) begin
                    store.wave = v[2:0];
                end else begin
                    store.wtime[p - 2'h1] = v;
                end
            end
            default: store = cf;
        endcase
    endfunction

    logic [7:0]  b;
    logic [7:0]  ch;
    logic        is_end;
    logic        is_let;
    logic        is_com;
    logic        polled;
    logic [19:0] prod;

    always_comb begin
        s_d = s_q;
        b = {1'b0, dio_in[6:0]};
        ch = s_q.buff[s_q.idx[4:0]];
        is_end = s_q.idx == s_q.cnt;
        is_let = !is_end && ch >= `GCP_CH_A && ch <= `GCP_CH_Z;
        is_com = !is_end && ch == `GCP_CH_COMMA;
        prod = 20'h00000;
        s_d.restore = 1'b0;
        s_d.drift_clr = 1'b0;
        s_d.trig_single = 1'b0;
        s_d.trig_sweep = 1'b0;
        polled = s_q.spe && s_q.talk && !atn;
        s_d.dio_oe = polled;
        s_d.dio_out = status_byte;
        s_d.dio_out[`GCP_RQS] = s_q.srq;
        if (polled) begin
            s_d.srq = 1'b0;
        end
        if (atn && dav) begin
            if (b == {`GCP_LAD, my_addr}) begin
                s_d.lstn = 1'b1;
            end else if (b == `GCP_UNL) begin
                s_d.lstn = 1'b0;
            end
            if (b[7:5] == `GCP_TAD) begin
                s_d.talk = b[4:0] == my_addr;
            end
            if (b == `GCP_SPE) begin
                s_d.spe = 1'b1;
            end
            if (b == `GCP_SPD) begin
                s_d.spe = 1'b0;
            end
            if (b == `GCP_DCL) begin
                s_d.drift_clr = 1'b1;
            end
            if (b == `GCP_GET && s_q.lstn && s_q.live.tmode == `GCP_TM_GET) begin
                s_d.trig_single = !s_q.live.tshape;
                s_d.trig_sweep = s_q.live.tshape;
            end
        end
        unique case (s_q.st)
        gcp_pkg::GCP_COLLECT: begin
            if (!atn && dav && s_q.lstn) begin
                if (b == `GCP_CH_X) begin
                    s_d.st = gcp_pkg::GCP_SCAN;
                    s_d.idx = '0;
                    s_d.sh = s_q.live;
                    s_d.cmd = 8'h00;
                    s_d.have = 1'b0;
                    s_d.any = 1'b0;
                    s_d.neg = 1'b0;
                    s_d.acc = 16'h0000;
                    s_d.cerr = s_q.ovf;
                    s_d.oerr = 1'b0;
                end else if (s_q.cnt == `GCP_CNT_FULL) begin
                    s_d.ovf = 1'b1;
                end else begin
                    s_d.buff[s_q.cnt[4:0]] = b;
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
        end
        gcp_pkg::GCP_SCAN: begin
            // Close the pending parameter before a letter, comma or end
            if ((is_end || is_let || is_com) && s_q.cmd != 8'h00 && s_q.have) begin
                if (!param_ok(s_q.cmd, s_q.pidx, s_q.acc, s_q.neg)) begin
                    s_d.oerr = 1'b1;
                end else begin
                    s_d.sh = store(s_q.sh, s_q.cmd, s_q.pidx, s_q.acc, s_q.neg);
                end
            end
            if ((is_end || is_let) && s_q.cmd != 8'h00 && !s_q.any) begin
                s_d.oerr = 1'b1;
            end
            s_d.idx = s_q.idx + 1'b1;
            if (is_end) begin
                // Whole string commits at once, so category order is implicit
                if (!s_d.cerr && !s_d.oerr) begin
                    s_d.live = s_d.sh;
                    if (s_d.sh.tmode == `GCP_TM_X) begin
                        s_d.trig_single = !s_d.sh.tshape;
                        s_d.trig_sweep = s_d.sh.tshape;
                    end
                end
                s_d.bad_cmd = s_d.cerr;
                s_d.bad_opt = s_d.oerr && !s_d.cerr;
                if ((s_d.cerr || s_d.oerr) && srq_on_error) begin
                    s_d.srq = 1'b1;
                end
                s_d.st = gcp_pkg::GCP_COLLECT;
                s_d.cnt = '0;
                s_d.ovf = 1'b0;
            end else if (is_let) begin
                s_d.cmd = ch;
                s_d.pidx = 2'h0;
                s_d.any = 1'b0;
                s_d.have = 1'b0;
                s_d.neg = 1'b0;
                s_d.acc = 16'h0000;
                if (nparam(ch) == 3'h0) begin
                    s_d.cerr = 1'b1;
                end
            end else if (is_com) begin
                s_d.any = 1'b1;
                s_d.have = 1'b0;
                s_d.neg = 1'b0;
                s_d.acc = 16'h0000;
                if (s_q.cmd == 8'h00) begin
                    s_d.cerr = 1'b1;
                end else if ({1'b0, s_q.pidx} + 3'h1 >= nparam(s_q.cmd)) begin
                    s_d.oerr = 1'b1;
                end else begin
                    s_d.pidx = s_q.pidx + 2'h1;
                end
            end else if (ch >= `GCP_CH_0 && ch <= `GCP_CH_9) begin
                prod = {4'h0, s_q.acc} * `GCP_TEN + {16'h0000, ch[3:0]};
                // Saturate so oversize numbers still fail the limit check
                s_d.acc = prod > `GCP_ACC_SAT ? 16'hffff : prod[15:0];
                s_d.have = 1'b1;
                s_d.any = 1'b1;
                if (s_q.cmd == 8'h00) begin
                    s_d.cerr = 1'b1;
                end
            end else if (ch == `GCP_CH_MINUS) begin
                s_d.neg = 1'b1;
                if (s_q.have || s_q.cmd != `GCP_CH_V) begin
                    s_d.oerr = 1'b1;
                end
            end else if (ch != `GCP_CH_SP) begin
                s_d.cerr = 1'b1;
            end
        end
        endcase
        // Clear comes last so it overrides any parse in flight
        if (atn && dav && b == `GCP_SDC && s_q.lstn) begin
            s_d.live = '0;
            s_d.restore = 1'b1;
            s_d.drift_clr = 1'b1;
            s_d.st = gcp_pkg::GCP_COLLECT;
            s_d.cnt = '0;
            s_d.ovf = 1'b0;
        end
        // Not ready while a string is being checked
        s_d.nrfd = s_d.st == gcp_pkg::GCP_SCAN;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dio_out = s_q.dio_out;
    assign dio_oe = s_q.dio_oe;
    assign nrfd = s_q.nrfd;
    assign srq = s_q.srq;
    assign bad_command_error = s_q.bad_cmd;
    assign bad_option_error = s_q.bad_opt;
    assign restore_setup1 = s_q.restore;
    assign drift_null_clear = s_q.drift_clr;
    assign trig_single = s_q.trig_single;
    assign trig_sweep = s_q.trig_sweep;
    assign freq_q = s_q.live.freq;
    assign range_q = s_q.live.range;
    assign rate_q = s_q.live.rate;
    assign trig_mode_q = s_q.live.tmode;
    assign trig_shape_q = s_q.live.tshape;
    assign bias_level_q = s_q.live.bias;
    assign wave_q = s_q.live.wave;
    assign wave_time_q = s_q.live.wtime;
    assign k_opt_q = s_q.live.kopt;
    assign z_opt_q = s_q.live.zopt;

    a_sdc_restore: assert property (@(posedge core_clk) disable iff (!nrst)
        atn && dav && dio_in[6:0] == `GCP_SDC && s_q.lstn |=> restore_setup1 && range_q == '0)
        else $error("SDC while listening did not restore");
    a_sdc_unaddr: assert property (@(posedge core_clk) disable iff (!nrst)
        restore_setup1 |-> $past(s_q.lstn) && $past(atn))
        else $error("restore without being addressed listener");
    a_get_trig: assert property (@(posedge core_clk) disable iff (!nrst)
        atn && dav && dio_in[6:0] == `GCP_GET && s_q.lstn && trig_mode_q == `GCP_TM_GET
        |=> trig_single != trig_sweep)
        else $error("GET in GET trigger mode gave no trigger");
    a_spe_enter: assert property (@(posedge core_clk) disable iff (!nrst)
        atn && dav && dio_in[6:0] == `GCP_SPE |=> s_q.spe)
        else $error("SPE did not enable serial poll");
    a_poll_drive: assert property (@(posedge core_clk) disable iff (!nrst)
        s_q.spe && s_q.talk && !atn |=> dio_oe && dio_out[5:0] == $past(status_byte[5:0]))
        else $error("status byte not driven during poll");
    a_spd_leave: assert property (@(posedge core_clk) disable iff (!nrst)
        atn && dav && dio_in[6:0] == `GCP_SPD |=> !s_q.spe ##1 !dio_oe)
        else $error("SPD did not end serial poll");
    a_late_error: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(bad_command_error) || $rose(bad_option_error)
        |-> $past(s_q.st) == gcp_pkg::GCP_SCAN)
        else $error("error raised before execute");
    a_atomic_reject: assert property (@(posedge core_clk) disable iff (!nrst)
        ($rose(bad_option_error) || $rose(bad_command_error)) && !restore_setup1
        |-> $stable(s_q.live))
        else $error("rejected string changed configuration");
    a_buf_empty: assert property (@(posedge core_clk) disable iff (!nrst)
        s_q.st == gcp_pkg::GCP_SCAN ##1 s_q.st == gcp_pkg::GCP_COLLECT |-> s_q.cnt == '0)
        else $error("buffer not emptied after execute");
    a_bias_range: assert property (@(posedge core_clk) disable iff (!nrst)
        $signed(bias_level_q[0]) <= 6'sd20 && $signed(bias_level_q[0]) >= -6'sd20)
        else $error("bias level beyond limit");

endmodule
`default_nettype wire
